// ===== include/ecis_pkg.sv
// package of register map, field layout and reset values for the event channel interrupt status block
package ecis_pkg;
	localparam int ECIS_NCH = 12;
	localparam logic [7:0] ECIS_OFF_STATUS = 8'h0c;
	localparam logic [7:0] ECIS_OFF_IEN_CLR = 8'h10;
	localparam logic [7:0] ECIS_OFF_IEN_SET = 8'h14;
	localparam logic [7:0] ECIS_OFF_FLAGS = 8'h18;
	localparam logic [7:0] ECIS_OFF_PATH_ASYNC = 8'h1c;
	localparam logic [11:0] ECIS_EN_RESET = 12'h000;
	localparam logic [11:0] ECIS_FLAG_RESET = 12'h000;
	localparam logic [11:0] ECIS_PATH_RESET = 12'h000;
	localparam logic [31:0] ECIS_RD_UNMAPPED = 32'h00000000;

	// scatter 12 channel bits: low byte group at lo_pos, upper four at hi_pos
	function automatic logic [31:0] ecis_place(input logic [11:0] v, input int lo_pos, input int hi_pos);
		logic [31:0] r;
		r = 32'h00000000;
		r[lo_pos +: 8] = v[7:0];
		r[hi_pos +: 4] = v[11:8];
		return r;
	endfunction

	function automatic logic [11:0] ecis_pick(input logic [31:0] w, input int lo_pos, input int hi_pos);
		return {w[hi_pos +: 4], w[lo_pos +: 8]};
	endfunction

	// event-detected: bits 8..15 then 24..27; overrun: bits 0..7 then 16..19
	localparam int ECIS_EVD_LO = 8;
	localparam int ECIS_EVD_HI = 24;
	localparam int ECIS_OVR_LO = 0;
	localparam int ECIS_OVR_HI = 16;
endpackage

// ===== rtl/ecis_flag_bank.sv
// one bank of twelve sticky interrupt flags with write-one-to-clear
`timescale 1ns/100ps
module ecis_flag_bank
	import ecis_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [11:0] set_i,
	input wire logic [11:0] block_i,
	input wire logic [11:0] clr_i,
	output logic [11:0] flag_o
);
	genvar g;
	generate
		for (g = 0; g < ECIS_NCH; g++) begin : g_ch
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					flag_o[g] <= ECIS_FLAG_RESET[g];
				end else if (set_i[g] && !block_i[g]) begin
					// set wins over a clear in the same cycle
					flag_o[g] <= 1'b1;
				end else if (clr_i[g]) begin
					flag_o[g] <= 1'b0;
				end
			end
		end
	endgenerate
endmodule

// ===== rtl/ecis_top.sv
// top of the event channel interrupt status block with its wishbone slave
// Operation
// - user-ready per channel is one only when all attached users are ready
// - writing one to clear register event bit clears that event enable
// - writing one to clear register overrun bit clears overrun enable; reads show enables
// - writing one to set register event bit sets that event enable
// - writing one to set register overrun bit sets overrun enable; reads show enables
// - event flag sets the cycle after a channel event; interrupts when enabled
// - channels on the asynchronous path never set their event flag
// - overrun flag sets the cycle after an overrun; interrupts when enabled
// - channels on the asynchronous path never set their overrun flag
// - writing one to an event flag position clears that flag
// - writing one to an overrun flag position clears that flag
// - event bits sit at 8..15,24..27; overrun bits at 0..7,16..19
// - busy while an event is not yet handled by every attached user
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/100ps
module ecis_top
	import ecis_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [11:0] channel_event_i,
	input wire logic [11:0] channel_overrun_i,
	input wire logic [11:0] channel_users_ready_i,
	input wire logic [11:0] channel_pending_i,
	output logic [11:0] channel_users_ready_o,
	output logic [11:0] channel_busy_o,
	output logic irq_o
);
	logic [11:0] evd_en_q;
	logic [11:0] ovr_en_q;
	logic [11:0] path_async_q;
	logic [11:0] evd_flag;
	logic [11:0] ovr_flag;
	logic [11:0] evd_clr;
	logic [11:0] ovr_clr;
	logic [31:0] wmask;
	logic [31:0] wbits;
	logic [31:0] rd_d;
	logic req;
	logic wr;

	// a request is answered one cycle later; ack is dropped for one cycle between requests
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = req && wb_we_i;
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wbits = wb_dat_i & wmask;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evd_en_q <= ECIS_EN_RESET;
			ovr_en_q <= ECIS_EN_RESET;
		end else if (wr && wb_adr_i == ECIS_OFF_IEN_CLR) begin
			evd_en_q <= evd_en_q & ~ecis_pick(wbits, ECIS_EVD_LO, ECIS_EVD_HI);
			ovr_en_q <= ovr_en_q & ~ecis_pick(wbits, ECIS_OVR_LO, ECIS_OVR_HI);
		end else if (wr && wb_adr_i == ECIS_OFF_IEN_SET) begin
			evd_en_q <= evd_en_q | ecis_pick(wbits, ECIS_EVD_LO, ECIS_EVD_HI);
			ovr_en_q <= ovr_en_q | ecis_pick(wbits, ECIS_OVR_LO, ECIS_OVR_HI);
		end
	end

	// path select is a plain control word here since channel setup lives elsewhere
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			path_async_q <= ECIS_PATH_RESET;
		end else if (wr && wb_adr_i == ECIS_OFF_PATH_ASYNC) begin
			path_async_q <= {wbits[27:24], wbits[15:8]};
		end
	end

	always_comb begin
		evd_clr = 12'h000;
		ovr_clr = 12'h000;
		if (wr && wb_adr_i == ECIS_OFF_FLAGS) begin
			evd_clr = ecis_pick(wbits, ECIS_EVD_LO, ECIS_EVD_HI);
			ovr_clr = ecis_pick(wbits, ECIS_OVR_LO, ECIS_OVR_HI);
		end
	end

	ecis_flag_bank u_evd (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.set_i(channel_event_i),
		.block_i(path_async_q),
		.clr_i(evd_clr),
		.flag_o(evd_flag)
	);

	ecis_flag_bank u_ovr (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.set_i(channel_overrun_i),
		.block_i(path_async_q),
		.clr_i(ovr_clr),
		.flag_o(ovr_flag)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			// registered, so the line follows the flags by one cycle
			irq_o <= |((evd_flag & evd_en_q) | (ovr_flag & ovr_en_q));
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			channel_users_ready_o <= 12'h000;
			channel_busy_o <= 12'h000;
		end else begin
			channel_users_ready_o <= channel_users_ready_i;
			channel_busy_o <= channel_pending_i;
		end
	end

	always_comb begin
		rd_d = ECIS_RD_UNMAPPED;
		unique case (wb_adr_i)
			ECIS_OFF_STATUS: begin
				rd_d = ecis_place(channel_busy_o, ECIS_EVD_LO, ECIS_EVD_HI)
					| ecis_place(channel_users_ready_o, ECIS_OVR_LO, ECIS_OVR_HI);
			end
			ECIS_OFF_IEN_CLR, ECIS_OFF_IEN_SET: begin
				rd_d = ecis_place(evd_en_q, ECIS_EVD_LO, ECIS_EVD_HI) | ecis_place(ovr_en_q, ECIS_OVR_LO, ECIS_OVR_HI);
			end
			ECIS_OFF_FLAGS: begin
				rd_d = ecis_place(evd_flag, ECIS_EVD_LO, ECIS_EVD_HI) | ecis_place(ovr_flag, ECIS_OVR_LO, ECIS_OVR_HI);
			end
			ECIS_OFF_PATH_ASYNC: begin
				rd_d = ecis_place(path_async_q, ECIS_EVD_LO, ECIS_EVD_HI);
			end
			default: begin
				rd_d = ECIS_RD_UNMAPPED;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h00000000;
		end else if (req) begin
			wb_dat_o <= rd_d;
		end
	end
endmodule

// ===== bench/ecis_chk_sva.sv
// checker of bus handshake, status copies and interrupt causes
`timescale 1ns/100ps
module ecis_chk(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [11:0] channel_event_i,
	input wire logic [11:0] channel_overrun_i,
	input wire logic [11:0] channel_users_ready_i,
	input wire logic [11:0] channel_pending_i,
	input wire logic [11:0] channel_users_ready_o,
	input wire logic [11:0] channel_busy_o,
	input wire logic irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	// irq rises two edges after an event, overrun or enable write
	sequence s_cause; $past(|channel_event_i || |channel_overrun_i || wb_cyc_i && wb_we_i, 2); endsequence
	property p_ack; s_req |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack missing");
	property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack1: assert property (p_ack1) else $error("ack too long");
	property p_idle; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
	a_idle: assert property (p_idle) else $error("ack without request");
	property p_hold; !wb_ack_o |-> $stable(wb_dat_o); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_rdy; !rst_i |=> channel_users_ready_o == $past(channel_users_ready_i); endproperty
	a_rdy: assert property (p_rdy) else $error("ready copy wrong");
	property p_busy; !rst_i |=> channel_busy_o == $past(channel_pending_i); endproperty
	a_busy: assert property (p_busy) else $error("busy copy wrong");
	property p_irq; $rose(irq_o) |-> s_cause; endproperty
	a_irq: assert property (p_irq) else $error("irq without cause");
	property p_rst; disable iff (1'b0) rst_i |=> !wb_ack_o && !irq_o && channel_busy_o == 12'h000; endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared");
endmodule

// ===== bench/ecis_far_model.sv
// far side: generators pulse one cycle, two users per channel report ready
`timescale 1ns/100ps
module ecis_far_model(
	input wire logic clk_i,
	input wire logic [11:0] ev_i,
	input wire logic [11:0] ov_i,
	input wire logic [11:0] ua_i,
	input wire logic [11:0] ub_i,
	output logic [11:0] channel_event_o = 12'h000,
	output logic [11:0] channel_overrun_o = 12'h000,
	output logic [11:0] channel_users_ready_o
);
	assign channel_users_ready_o = ua_i & ub_i;
	always @(posedge clk_i) begin
		channel_event_o <= ev_i;
		channel_overrun_o <= ov_i;
	end
endmodule

// ===== bench/tb.sv
// register, interrupt and status bench
`timescale 1ns/100ps
module tb
	import ecis_pkg::*;
;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, ack, irq;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hf;
	logic [31:0] dat = 32'h00000000, dat_o, rdat;
	logic [11:0] ev = 12'h000, ov = 12'h000, ua = 12'h000, ub = 12'h000, pend = 12'h000;
	logic [11:0] ch_ev, ch_ov, rdy, rdy_o, busy_o;
	int n_fail = 0, total_checks = 0, cycles = 0;
	initial forever #10 clk_i = ~clk_i;
	ecis_far_model FAR(.clk_i(clk_i), .ev_i(ev), .ov_i(ov), .ua_i(ua), .ub_i(ub),
		.channel_event_o(ch_ev), .channel_overrun_o(ch_ov), .channel_users_ready_o(rdy));
	ecis_top DUT(.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.channel_event_i(ch_ev), .channel_overrun_i(ch_ov), .channel_users_ready_i(rdy),
		.channel_pending_i(pend), .channel_users_ready_o(rdy_o), .channel_busy_o(busy_o), .irq_o(irq));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rdat = dat_o;
		cyc <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		acc(a, 1'b0, 32'h00000000);
		chk(rdat, exp);
	endtask
	task automatic irq_is(input logic exp);
		@(posedge clk_i);
		chk({31'h00000000, irq}, {31'h00000000, exp});
	endtask
	task automatic pulse(input logic [11:0] e, input logic [11:0] o);
		@(posedge clk_i);
		ev <= e;
		ov <= o;
		@(posedge clk_i);
		ev <= 12'h000;
		ov <= 12'h000;
	endtask
	task automatic end_of_test;
		if (n_fail == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// well above the fewer than one hundred cycles the sequence needs
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			end_of_test();
		end
	end
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(ECIS_OFF_IEN_CLR, 32'h00000000);
		rd(ECIS_OFF_FLAGS, 32'h00000000);
		acc(ECIS_OFF_IEN_SET, 1'b1, 32'h0f0fffff);
		acc(ECIS_OFF_IEN_CLR, 1'b1, 32'h01000001);
		rd(ECIS_OFF_IEN_SET, 32'h0e0ffffe);
		rd(ECIS_OFF_IEN_CLR, 32'h0e0ffffe);
		pulse(12'h800, 12'h008);
		rd(ECIS_OFF_FLAGS, 32'h08000008);
		irq_is(1'b1);
		acc(ECIS_OFF_IEN_CLR, 1'b1, 32'h08000008);
		irq_is(1'b0);
		acc(ECIS_OFF_FLAGS, 1'b1, 32'h00000008);
		rd(ECIS_OFF_FLAGS, 32'h08000000);
		acc(ECIS_OFF_FLAGS, 1'b1, 32'h08000000);
		rd(ECIS_OFF_FLAGS, 32'h00000000);
		acc(ECIS_OFF_PATH_ASYNC, 1'b1, 32'h00000100);
		pulse(12'h001, 12'h001);
		rd(ECIS_OFF_FLAGS, 32'h00000000);
		ua <= 12'hfff;
		ub <= 12'h7fe;
		pend <= 12'h801;
		rd(ECIS_OFF_STATUS, 32'h080701fe);
		// a write whose only set bits sit in a disabled byte lane must change nothing
		sel <= 4'he;
		acc(ECIS_OFF_IEN_SET, 1'b1, 32'h000000ff);
		sel <= 4'hf;
		rd(ECIS_OFF_IEN_SET, 32'h060ffff6);
		rd(8'h20, ECIS_RD_UNMAPPED);
		end_of_test();
	end
endmodule
bind ecis_top ecis_chk u_chk(.*);
